// [dv/rcb_host_model.sv]
// rcb_host_model: host that requests a reconfiguration and streams image words.
// assumes aclk at 4 ns; link clock made only inside a frame, 160 ns period.
`timescale 1ns/1ns
module rcb_host_model (
  // sampling clock and status
  input wire logic  aclk,
  input wire logic  reconfig_ready,
  // link outputs
  output logic        reconfig_clock,
  output logic        reconfig_request,
  output logic [31:0] image_data
);
  import rcb_pkg::*;
  initial begin
    reconfig_clock = 1'b0;
    reconfig_request <= 1'b0;
    image_data = 32'hFFFF_FFFF;
  end
  // half a link period, offset from aclk so phases stay apart
  task automatic half();
    repeat (20) @(posedge aclk);
    #1;
  endtask
  // data set at the fall, held 80 ns past the rise
  task automatic put_word(input logic [31:0] w);
    image_data = w;
    half();
    reconfig_clock = 1'b1;
    half();
    reconfig_clock = 1'b0;
  endtask
  // raise request, no words before ready
  task automatic request_up(output bit ok);
    ok = 1'b0;
    reconfig_request <= 1'b1;
    for (int i = 0; i < 200 && !ok; i++) begin
      @(posedge aclk);
      ok = (reconfig_ready === 1'b1);
    end
  endtask
  task automatic request_down();
    @(posedge aclk);
    #1;
    reconfig_request <= 1'b0;
  endtask
  // zero padding, header, id, four counts
  task automatic send_image(input int pads, input logic [31:0] hdr, input logic [31:0] id,
                            input logic [31:0] c2);
    for (int i = 0; i < pads; i++) put_word(RCB_PAD_WORD);
    put_word(hdr);
    put_word(id);
    put_word(RCB_CNT0_WORD);
    put_word(RCB_CNT1_WORD);
    put_word(c2);
    put_word(RCB_CNT3_WORD);
    image_data = ~image_data; // released line shows no stale word
  endtask
endmodule

// [dv/rcb_top_bench.sv]
// rcb_top_bench: register and image tests of the reconfig block model.
// assumes rcb_host_model on the link side and the bound checker.
`timescale 1ns/1ns
module rcb_top_bench;
  import rcb_pkg::*;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
  logic        s_axi_rready, reconfig_clock, reconfig_request, reconfig_ready, reconfig_done;
  logic        reconfig_error, region_activation, irq, s_axi_awready, s_axi_wready;
  logic        s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_wdata, image_data, model_persona_id_out, s_axi_rdata;
  rcb_event_t  model_event_state;
  int          bad_count, compares;
  bit          act_on, seen;
  rcb_top rcb_top_i (.aclk, .aresetn, .reconfig_clock, .reconfig_request, .image_data,
    .reconfig_ready, .reconfig_done, .reconfig_error, .model_event_state,
    .model_persona_id_out, .region_activation, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  rcb_host_model host_i (.aclk, .reconfig_ready, .reconfig_clock, .reconfig_request,
    .image_data);
  initial begin
    aclk = 1'b0;
    forever #2 aclk = ~aclk;
  end
  task automatic stop_test();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic cmp_bit(input string nm, input logic e, input logic g);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s exp %b got %b", nm, e, g);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit aw, w;
    aw = 1'b0;
    w = 1'b0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) aw = 1'b1;
      if (s_axi_wvalid && s_axi_wready) w = 1'b1;
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    cmp_word("bresp", {30'h0, er}, {30'h0, s_axi_bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    cmp_word("rdata", ed, s_axi_rdata);
    cmp_word("rresp", {30'h0, er}, {30'h0, s_axi_rresp});
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 100 && model_event_state !== RCB_IDLE; i++) @(posedge aclk);
    #1;
    cmp_word("idle", RCB_IDLE, model_event_state);
  endtask
  // one full image and its outcome
  task automatic run_img(input int pads, input logic [31:0] hdr, input logic [31:0] id,
                         input logic [31:0] c2, input rcb_event_t ex);
    bit ok;
    host_i.request_up(ok);
    cmp_bit("ready", 1'b1, ok);
    #1;
    cmp_bit("activation", act_on, region_activation);
    host_i.send_image(pads, hdr, id, c2);
    for (int i = 0; i < 100 && !reconfig_done && !reconfig_error; i++) @(posedge aclk);
    #1;
    cmp_word("state", ex, model_event_state);
    cmp_bit("done", ex == RCB_SUCCEEDED, reconfig_done);
    cmp_bit("error", ex == RCB_FAILED, reconfig_error);
    if (hdr == RCB_HEADER_WORD) cmp_word("persona", id, model_persona_id_out);
    host_i.request_down();
    wait_idle();
  endtask
  initial begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    stop_test();
  end
  // main sequence: registers, good image, bad images, withdraw
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    act_on = 1'b1;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    wait_idle();
    rd(RCB_OFS_ACT_MODE, 32'h0000_7FFF, RCB_RESP_OKAY);
    rd(RCB_OFS_ACT_CTRL, 32'h0000_0001, RCB_RESP_OKAY);
    rd(RCB_OFS_IRQ_MASK, 32'h0000_0000, RCB_RESP_OKAY);
    rd(8'h40, 32'h0000_0000, RCB_RESP_SLVERR);
    wr(RCB_OFS_STATE, 32'h0000_0005, RCB_RESP_OKAY);
    rd(RCB_OFS_STATE, 32'h0000_0001, RCB_RESP_OKAY);
    wr(RCB_OFS_IRQ_MASK, 32'h0000_0001, RCB_RESP_OKAY);
    wr(RCB_OFS_ACT_MODE, 32'h0000_113A, RCB_RESP_OKAY);
    wr(RCB_OFS_ACT_USER, 32'hC0DE_0042, RCB_RESP_OKAY);
    wr(RCB_OFS_REGION, 32'hFFFF_FFFF, RCB_RESP_OKAY);
    wr(RCB_OFS_REGION + 8'h04, 32'h0000_0000, RCB_RESP_OKAY);
    run_img(2, RCB_HEADER_WORD, 32'h0000_5A01, RCB_CNT2_WORD, RCB_SUCCEEDED);
    rd(RCB_OFS_PERSONA, 32'h0000_5A01, RCB_RESP_OKAY);
    rd(RCB_OFS_REGION, 32'h0000_0000, RCB_RESP_OKAY);
    rd(RCB_OFS_REGION + 8'h04, 32'hFFFF_FFFF, RCB_RESP_OKAY);
    rd(RCB_OFS_REGION + 8'h08, 32'hC0DE_0042, RCB_RESP_OKAY);
    rd(RCB_OFS_REGION + 8'h0C, RCB_UNK_PATTERN, RCB_RESP_OKAY);
    cmp_bit("irq", 1'b1, irq);
    wr(RCB_OFS_IRQ_STAT, 32'h0000_0007, RCB_RESP_OKAY);
    cmp_bit("irq", 1'b0, irq);
    run_img(0, 32'h0000_A65D, 32'h0000_5A02, RCB_CNT2_WORD, RCB_FAILED);
    cmp_bit("irq", 1'b0, irq);
    rd(RCB_OFS_IRQ_STAT, 32'h0000_0002, RCB_RESP_OKAY);
    wr(RCB_OFS_IRQ_MASK, 32'h0000_0007, RCB_RESP_OKAY);
    cmp_bit("irq", 1'b1, irq);
    wr(RCB_OFS_IRQ_STAT, 32'h0000_0007, RCB_RESP_OKAY);
    run_img(1, RCB_HEADER_WORD, 32'h0000_5A03, 32'h0246_8ACF, RCB_FAILED);
    wr(RCB_OFS_IRQ_STAT, 32'h0000_0007, RCB_RESP_OKAY);
    act_on = 1'b0;
    wr(RCB_OFS_ACT_CTRL, 32'h0000_0000, RCB_RESP_OKAY);
    host_i.request_up(seen);
    #1;
    cmp_bit("activation", 1'b0, region_activation);
    seen = 1'b0;
    host_i.request_down();
    for (int i = 0; i < 20; i++) begin
      @(posedge aclk);
      if (model_event_state === RCB_LATE_WITHDRAW) seen = 1'b1;
    end
    cmp_bit("late", 1'b1, seen);
    wait_idle();
    rd(RCB_OFS_IRQ_STAT, 32'h0000_0004, RCB_RESP_OKAY);
    stop_test();
  end
endmodule

// [dv/rcb_top_sva.sv]
// rcb_top_sva: port-level checks on the reconfig block model.
// assumes the one aclk domain; bound into every rcb_top.
`timescale 1ns/1ns
module rcb_top_sva (
  // clock and reset
  input wire logic          aclk,
  input wire logic          aresetn,
  // link status
  input wire logic          reconfig_ready,
  input wire logic          reconfig_done,
  input wire logic          reconfig_error,
  input rcb_pkg::rcb_event_t model_event_state,
  input wire logic [31:0]   model_persona_id_out,
  input wire logic          region_activation,
  // bus answers
  input wire logic          s_axi_arready,
  input wire logic          s_axi_bvalid,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_rvalid,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_rready
);
  import rcb_pkg::*;
  rcb_event_t st;
  assign st = model_event_state;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // steps of a reconfiguration
  sequence s_req;
    st == RCB_REQUEST;
  endsequence
  sequence s_wdrw;
    st inside {RCB_EARLY_WITHDRAW, RCB_LATE_WITHDRAW};
  endsequence
  chk_state_legal: assert property (st <= RCB_LATE_WITHDRAW)
    else $error("event state outside the enumeration");
  chk_ready_run: assert property (reconfig_ready == (st == RCB_RUNNING))
    else $error("ready differs from running state");
  chk_done_ok: assert property (reconfig_done == (st == RCB_SUCCEEDED))
    else $error("done differs from success state");
  chk_error_fail: assert property (reconfig_error == (st == RCB_FAILED))
    else $error("error differs from failed state");
  chk_req_step: assert property (s_req |=> st inside {RCB_RUNNING, RCB_EARLY_WITHDRAW})
    else $error("request state not followed by running");
  chk_wdrw_short: assert property (s_wdrw |=> st == RCB_IDLE)
    else $error("withdraw state lasted over one cycle");
  chk_idle_exit: assert property ($past(st) == RCB_IDLE && st != RCB_IDLE |-> s_req)
    else $error("idle left for a state other than request");
  chk_act_run: assert property (region_activation |-> st == RCB_RUNNING)
    else $error("activation outside running state");
  chk_persona_keep: assert property
    (st == RCB_SUCCEEDED && $past(st) == RCB_SUCCEEDED |-> $stable(model_persona_id_out))
    else $error("persona id moved after success");
  chk_bvalid_hold: assert property
    (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  chk_rvalid_hold: assert property
    (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  chk_ar_refuse: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read address taken while data pending");
endmodule
bind rcb_top rcb_top_sva rcb_top_sva_i (.aclk, .aresetn, .reconfig_ready, .reconfig_done,
  .reconfig_error, .model_event_state, .model_persona_id_out, .region_activation,
  .s_axi_arready, .s_axi_bvalid, .s_axi_bresp, .s_axi_bready, .s_axi_rvalid,
  .s_axi_rdata, .s_axi_rready);

// [src/rcb_pkg.sv]
// rcb_pkg: constants, register map and state enumeration for the reconfig block model.
// assumes one 250 MHz aclk domain; the reconfig clock is sampled, never used as a clock.
// Function
// R1: image words taken on reconfig clock rising edges
// R2: event state reported as 32-bit enumeration
// R3: state and persona id exposed as outputs
// R4: host may lead with any zero padding words
// R5: host sends header, id, four count words
// R6: wrong header or count word ends failed
// R7: persona id driven from first count word
// R8: image ends in success or failure outcome
// R9: host side activates region while running
// R10: host selects persona from id on success
// R11: activation loads every region register value
// R12: activation value per register or global
// R13: request, ready, run, then done or error
package rcb_pkg;

  // event state; order fixes the encoding 0..7
  typedef enum logic [31:0] {
    RCB_NONE,
    RCB_IDLE,
    RCB_REQUEST,
    RCB_RUNNING,
    RCB_SUCCEEDED,
    RCB_FAILED,
    RCB_EARLY_WITHDRAW,
    RCB_LATE_WITHDRAW
  } rcb_event_t;

  // position inside the image word sequence
  typedef enum logic [2:0] {
    RCB_W_HEADER,
    RCB_W_ID,
    RCB_W_CNT0,
    RCB_W_CNT1,
    RCB_W_CNT2,
    RCB_W_CNT3
  } rcb_step_t;

  // image word constants
  localparam logic [31:0] RCB_PAD_WORD    = 32'h0000_0000;
  localparam logic [31:0] RCB_HEADER_WORD = 32'h0000_A65C;
  localparam logic [31:0] RCB_CNT0_WORD   = 32'h0123_4567;
  localparam logic [31:0] RCB_CNT1_WORD   = 32'h89AB_CDEF;
  localparam logic [31:0] RCB_CNT2_WORD   = 32'h0246_8ACE;
  localparam logic [31:0] RCB_CNT3_WORD   = 32'h1357_9BDF;

  // register byte offsets
  localparam logic [7:0] RCB_OFS_STATE    = 8'h00;
  localparam logic [7:0] RCB_OFS_PERSONA  = 8'h04;
  localparam logic [7:0] RCB_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] RCB_OFS_IRQ_MASK = 8'h0C;
  localparam logic [7:0] RCB_OFS_ACT_MODE = 8'h10;
  localparam logic [7:0] RCB_OFS_ACT_USER = 8'h14;
  localparam logic [7:0] RCB_OFS_ACT_CTRL = 8'h18;
  localparam logic [7:0] RCB_OFS_REGION   = 8'h20;

  // region model: number of registers, mode field width
  localparam int          RCB_NREG       = 4;
  localparam int          RCB_MODE_W     = 3;
  localparam int          RCB_MODE_GLOB  = 12;
  // activation modes
  localparam logic [2:0]  RCB_MODE_UNK   = 3'h0;
  localparam logic [2:0]  RCB_MODE_ONE   = 3'h1;
  localparam logic [2:0]  RCB_MODE_ZERO  = 3'h2;
  localparam logic [2:0]  RCB_MODE_RAND  = 3'h3;
  localparam logic [2:0]  RCB_MODE_USER  = 3'h4;
  localparam logic [2:0]  RCB_MODE_GLOBAL = 3'h7;

  // reset values, unknown pattern and lfsr taps
  localparam logic [31:0] RCB_UNK_PATTERN  = 32'hDEAD_BEEF;
  localparam logic [31:0] RCB_LFSR_SEED    = 32'hACE1_2468;
  localparam logic [31:0] RCB_LFSR_TAPS    = 32'h8020_0003;
  localparam logic [14:0] RCB_RST_ACT_MODE = 15'h7FFF;
  localparam logic [0:0]  RCB_RST_ACT_CTRL = 1'h1;
  localparam logic [2:0]  RCB_RST_IRQ_MASK = 3'h0;

  // interrupt status bits
  localparam int RCB_IRQ_OK   = 0;
  localparam int RCB_IRQ_FAIL = 1;
  localparam int RCB_IRQ_WDRW = 2;

  // axi responses
  localparam logic [1:0] RCB_RESP_OKAY   = 2'h0;
  localparam logic [1:0] RCB_RESP_SLVERR = 2'h2;

endpackage

// [src/rcb_top.sv]
// rcb_top: reconfig block model with image checker, region model and axi4-lite registers.
// assumes reconfig_clock, reconfig request and image data come from outside aclk's domain,
// and data holds steady for at least a few aclk cycles after each reconfig clock rise.
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ns
module rcb_top (
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // reconfig link
  input  wire logic                  reconfig_clock,
  input  wire logic                  reconfig_request,
  input  wire logic [31:0]           image_data,
  output logic                       reconfig_ready,
  output logic                       reconfig_done,
  output logic                       reconfig_error,
  // model-only outputs
  output rcb_pkg::rcb_event_t        model_event_state,
  output logic [31:0]                model_persona_id_out,
  // region activation
  output logic                       region_activation,
  // interrupt
  output logic                       irq,
  // axi4-lite write address
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  // axi4-lite write data
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  // axi4-lite write response
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  // axi4-lite read address
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  // axi4-lite read data
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  import rcb_pkg::*;
  logic [2:0]  clk_sync_r;
  logic [2:0]  req_sync_r;
  logic        clk_lvl_r;
  logic        req_lvl_r;
  logic        clk_rise;
  logic [31:0] word_r;
  logic        word_vld_r;
  rcb_event_t  state_r;
  rcb_step_t   step_r;
  logic [31:0] id_r;
  logic [31:0] persona_r;
  logic [2:0]  irq_stat_r;
  logic [2:0]  irq_mask_r;
  logic [2:0]  irq_set;
  logic [14:0] act_mode_r;
  logic [31:0] act_user_r;
  logic [0:0]  act_ctrl_r;
  logic [31:0] lfsr_r;
  logic [31:0] region_r [RCB_NREG];
  logic [7:0]  aw_addr_r;
  logic        aw_have_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        w_have_r;
  logic        wr_go;
  logic        wr_hit;
  logic [31:0] rd_mux;
  logic        rd_hit;
  logic [31:0] data_sync_r [3];
  // three-stage samplers; only the last two stages are compared
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_sync_r <= 3'h0;
      req_sync_r <= 3'h0;
      data_sync_r <= '{default: 32'h0};
    end else begin
      clk_sync_r <= {clk_sync_r[1:0], reconfig_clock};
      req_sync_r <= {req_sync_r[1:0], reconfig_request};
      data_sync_r <= '{image_data, data_sync_r[0], data_sync_r[1]}; // [R1]
    end
  end
  // settled levels change only when stages two and three agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_lvl_r <= 1'b0;
      req_lvl_r <= 1'b0;
    end else begin
      if (clk_sync_r[1] == clk_sync_r[2]) clk_lvl_r <= clk_sync_r[2];
      if (req_sync_r[1] == req_sync_r[2]) req_lvl_r <= req_sync_r[2];
    end
  end
  assign clk_rise = clk_sync_r[1] & clk_sync_r[2] & ~clk_lvl_r; // [R1]
  // word capture at a detected rise; data and clock pass equal stages, so they stay paired
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      word_r     <= 32'h0;
      word_vld_r <= 1'b0;
    end else begin
      word_vld_r <= clk_rise && state_r == RCB_RUNNING; // [R1]
      if (clk_rise) word_r <= data_sync_r[2];
    end
  end
  // event state machine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_r <= RCB_NONE;
    end else begin
      case (state_r)
        RCB_NONE: state_r <= RCB_IDLE;
        RCB_IDLE: if (req_lvl_r) state_r <= RCB_REQUEST; // [R13]
        RCB_REQUEST: begin
          if (!req_lvl_r) state_r <= RCB_EARLY_WITHDRAW;
          else            state_r <= RCB_RUNNING; // [R13]
        end
        RCB_RUNNING: begin
          if (!req_lvl_r) begin
            state_r <= RCB_LATE_WITHDRAW;
          end else if (word_vld_r) begin
            case (step_r)
              RCB_W_HEADER: if (word_r != RCB_PAD_WORD && word_r != RCB_HEADER_WORD)
                state_r <= RCB_FAILED; // [R6]
              RCB_W_ID:   state_r <= RCB_RUNNING;
              RCB_W_CNT0: if (word_r != RCB_CNT0_WORD) state_r <= RCB_FAILED; // [R6]
              RCB_W_CNT1: if (word_r != RCB_CNT1_WORD) state_r <= RCB_FAILED; // [R6]
              RCB_W_CNT2: if (word_r != RCB_CNT2_WORD) state_r <= RCB_FAILED; // [R6]
              RCB_W_CNT3: begin
                if (word_r != RCB_CNT3_WORD) state_r <= RCB_FAILED; // [R6] [R8]
                else                         state_r <= RCB_SUCCEEDED; // [R8]
              end
              default: state_r <= RCB_FAILED;
            endcase
          end
        end
        // outcomes hold until the host drops its request
        RCB_SUCCEEDED, RCB_FAILED: if (!req_lvl_r) state_r <= RCB_IDLE;
        RCB_EARLY_WITHDRAW, RCB_LATE_WITHDRAW: state_r <= RCB_IDLE;
        default: state_r <= RCB_IDLE;
      endcase
    end
  end
  // step counter; zero words before the header are skipped as padding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      step_r <= RCB_W_HEADER;
    end else if (state_r != RCB_RUNNING) begin
      step_r <= RCB_W_HEADER;
    end else if (word_vld_r) begin
      case (step_r)
        RCB_W_HEADER: if (word_r == RCB_HEADER_WORD) step_r <= RCB_W_ID; // [R4] [R5]
        RCB_W_ID:     step_r <= RCB_W_CNT0;
        RCB_W_CNT0:   step_r <= RCB_W_CNT1;
        RCB_W_CNT1:   step_r <= RCB_W_CNT2;
        RCB_W_CNT2:   step_r <= RCB_W_CNT3;
        default:      step_r <= RCB_W_HEADER;
      endcase
    end
  end
  // persona id: caught at the id step, shown once the first count word is taken
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      id_r      <= 32'h0;
      persona_r <= 32'h0;
    end else if (state_r == RCB_RUNNING && word_vld_r) begin
      if (step_r == RCB_W_ID)   id_r      <= word_r;
      if (step_r == RCB_W_CNT0) persona_r <= id_r; // [R7]
    end
  end
  // link outputs are decoded from state, no extra delay
  assign model_event_state    = state_r; // [R2] [R3]
  assign model_persona_id_out = persona_r; // [R3]
  assign reconfig_ready       = state_r == RCB_RUNNING; // [R13]
  assign reconfig_done        = state_r == RCB_SUCCEEDED; // [R13]
  assign reconfig_error       = state_r == RCB_FAILED; // [R13]
  assign region_activation    = act_ctrl_r[0] && state_r == RCB_RUNNING; // [R9]
  // free-running random source for the random activation mode
  always_ff @(posedge aclk) begin
    if (!aresetn) lfsr_r <= RCB_LFSR_SEED;
    else          lfsr_r <= {lfsr_r[30:0], ^(lfsr_r & RCB_LFSR_TAPS)};
  end
  // region model registers: loaded every cycle while activation is high
  for (genvar g = 0; g < RCB_NREG; g++) begin : g_region
    logic [2:0]  mode;
    logic [31:0] load_val;
    assign mode = (act_mode_r[g*RCB_MODE_W +: RCB_MODE_W] == RCB_MODE_GLOBAL)
                  ? act_mode_r[RCB_MODE_GLOB +: RCB_MODE_W]
                  : act_mode_r[g*RCB_MODE_W +: RCB_MODE_W]; // [R12]
    always_comb begin
      case (mode)
        RCB_MODE_ONE:  load_val = 32'hFFFF_FFFF;
        RCB_MODE_ZERO: load_val = 32'h0000_0000;
        RCB_MODE_RAND: load_val = lfsr_r ^ (lfsr_r << (g + 1));
        RCB_MODE_USER: load_val = act_user_r;
        default:       load_val = RCB_UNK_PATTERN; // synthesizable stand-in for unknown
      endcase
    end
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        region_r[g] <= 32'h0;
      end else if (region_activation) begin
        region_r[g] <= load_val; // [R11]
      end else if (wr_go && aw_addr_r == RCB_OFS_REGION + 8'(4 * g)) begin
        region_r[g] <= w_data_r;
      end
    end
  end

  // interrupt events: set beats a same-cycle clear
  assign irq_set[RCB_IRQ_OK]   = state_r == RCB_RUNNING && word_vld_r && step_r == RCB_W_CNT3
                                 && word_r == RCB_CNT3_WORD && req_lvl_r;
  assign irq_set[RCB_IRQ_FAIL] = state_r != RCB_FAILED && state_r == RCB_RUNNING
                                 && req_lvl_r && word_vld_r
                                 && ((step_r == RCB_W_HEADER && word_r != RCB_PAD_WORD
                                      && word_r != RCB_HEADER_WORD)
                                     || (step_r == RCB_W_CNT0 && word_r != RCB_CNT0_WORD)
                                     || (step_r == RCB_W_CNT1 && word_r != RCB_CNT1_WORD)
                                     || (step_r == RCB_W_CNT2 && word_r != RCB_CNT2_WORD)
                                     || (step_r == RCB_W_CNT3 && word_r != RCB_CNT3_WORD));
  assign irq_set[RCB_IRQ_WDRW] = !req_lvl_r && (state_r == RCB_REQUEST
                                                || state_r == RCB_RUNNING);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_stat_r <= 3'h0;
    end else if (wr_go && aw_addr_r == RCB_OFS_IRQ_STAT && w_strb_r[0]) begin
      irq_stat_r <= (irq_stat_r & ~w_data_r[2:0]) | irq_set;
    end else begin
      irq_stat_r <= irq_stat_r | irq_set;
    end
  end

  assign irq = |(irq_stat_r & irq_mask_r);

  // axi write: address and data taken in either order, one response after both
  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready  = !w_have_r;
  assign wr_go         = aw_have_r && w_have_r && !s_axi_bvalid;
  assign wr_hit        = aw_addr_r[1:0] == 2'h0
                         && (aw_addr_r <= RCB_OFS_ACT_CTRL
                             || (aw_addr_r >= RCB_OFS_REGION
                                 && aw_addr_r < RCB_OFS_REGION + 8'(4 * RCB_NREG)));

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r    <= 1'b0;
      w_have_r     <= 1'b0;
      aw_addr_r    <= 8'h0;
      w_data_r     <= 32'h0;
      w_strb_r     <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RCB_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && !aw_have_r) begin
        aw_have_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_have_r) begin
        w_have_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_have_r    <= 1'b0;
        w_have_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_hit ? RCB_RESP_OKAY : RCB_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // writable control registers; full-word writes only, strobe lane 0 gates each
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= RCB_RST_IRQ_MASK;
      act_mode_r <= RCB_RST_ACT_MODE;
      act_user_r <= 32'h0;
      act_ctrl_r <= RCB_RST_ACT_CTRL;
    end else if (wr_go && w_strb_r[0]) begin
      case (aw_addr_r)
        RCB_OFS_IRQ_MASK: irq_mask_r <= w_data_r[2:0];
        RCB_OFS_ACT_MODE: act_mode_r <= w_data_r[14:0]; // [R12]
        RCB_OFS_ACT_USER: act_user_r <= w_data_r; // [R12]
        RCB_OFS_ACT_CTRL: act_ctrl_r <= w_data_r[0:0];
        default:          act_ctrl_r <= act_ctrl_r;
      endcase
    end
  end

  // read decode
  always_comb begin
    rd_mux = 32'h0;
    rd_hit = 1'b1;
    case (s_axi_araddr)
      RCB_OFS_STATE:    rd_mux = state_r;
      RCB_OFS_PERSONA:  rd_mux = persona_r;
      RCB_OFS_IRQ_STAT: rd_mux = {29'h0, irq_stat_r};
      RCB_OFS_IRQ_MASK: rd_mux = {29'h0, irq_mask_r};
      RCB_OFS_ACT_MODE: rd_mux = {17'h0, act_mode_r};
      RCB_OFS_ACT_USER: rd_mux = act_user_r;
      RCB_OFS_ACT_CTRL: rd_mux = {31'h0, act_ctrl_r};
      default: begin
        rd_hit = 1'b0;
        for (int i = 0; i < RCB_NREG; i++) begin
          if (s_axi_araddr == RCB_OFS_REGION + 8'(4 * i)) begin
            rd_mux = region_r[i];
            rd_hit = 1'b1;
          end
        end
      end
    endcase
  end

  // axi read: one outstanding read, answer one cycle after the address is taken
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
      s_axi_rresp  <= RCB_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_mux;
      s_axi_rresp  <= rd_hit ? RCB_RESP_OKAY : RCB_RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
